// >>> logic/vpcr_pkg.sv
package vpcr_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int VPCR_ADDR_W = 8;
    localparam int VPCR_DATA_W = 8;

    localparam logic [VPCR_ADDR_W-1:0] GENERAL_PIN_CONTROL_OFS = 8'h06;
    localparam logic [VPCR_ADDR_W-1:0] LOOPBACK_CONTROL_OFS = 8'h08;
    localparam logic [VPCR_ADDR_W-1:0] AUDIO_GAIN_CONTROL_OFS = 8'h09;
    localparam logic [VPCR_ADDR_W-1:0] IMPEDANCE_SYNTHESIS_CONTROL_OFS = 8'h0a;
    localparam logic [VPCR_ADDR_W-1:0] HYBRID_BALANCE_CONTROL_OFS = 8'h0b;

    // ****************************************************************
    // Reset values and writable masks
    // ****************************************************************
    localparam logic [7:0] GENERAL_PIN_CONTROL_RST = 8'h00;
    localparam logic [7:0] LOOPBACK_CONTROL_RST = 8'h02;
    localparam logic [7:0] AUDIO_GAIN_CONTROL_RST = 8'h00;
    localparam logic [7:0] IMPEDANCE_SYNTHESIS_CONTROL_RST = 8'h08;
    localparam logic [7:0] HYBRID_BALANCE_CONTROL_RST = 8'h33;

    localparam logic [7:0] GENERAL_PIN_CONTROL_MASK = 8'h1f;
    localparam logic [7:0] LOOPBACK_CONTROL_MASK = 8'h07;
    localparam logic [7:0] AUDIO_GAIN_CONTROL_MASK = 8'hff;
    localparam logic [7:0] IMPEDANCE_SYNTHESIS_CONTROL_MASK = 8'h3f;
    localparam logic [7:0] HYBRID_BALANCE_CONTROL_MASK = 8'h77;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int GP_OUT_PIN_VALUE_BIT = 4;
    localparam int GP_PIN2_DIRECTION_BIT = 3;
    localparam int GP_PIN1_DIRECTION_BIT = 2;
    localparam int GP_PIN2_VALUE_BIT = 1;
    localparam int GP_PIN1_VALUE_BIT = 0;

    localparam int ANALOG_LOOP_FULL_BIT = 2;
    localparam int DIGITAL_LOOP_ENABLE_BIT = 1;
    localparam int ANALOG_LOOP_FIRST_BIT = 0;

    localparam int RECEIVE_HPF_BYPASS_BIT = 7;
    localparam int TRANSMIT_HPF_BYPASS_BIT = 6;
    localparam int TRANSMIT_MUTE_BIT = 5;
    localparam int RECEIVE_MUTE_BIT = 4;
    localparam int TRANSMIT_ANALOG_GAIN_LSB = 2;
    localparam int RECEIVE_ANALOG_GAIN_LSB = 0;

    localparam int LINE_CAP_COMPENSATION_LSB = 4;
    localparam int IMPEDANCE_SYNTH_ENABLE_BIT = 3;
    localparam int IMPEDANCE_SYNTH_SELECT_LSB = 0;

    localparam int METERING_BALANCE_CODE_LSB = 4;
    localparam int AUDIO_BALANCE_CODE_LSB = 0;

    // ****************************************************************
    // Field codes
    // ****************************************************************
    localparam logic [1:0] ANALOG_GAIN_0DB = 2'h0;
    localparam logic [1:0] ANALOG_GAIN_MUTE = 2'h3;
    localparam logic [1:0] LINE_CAP_RESERVED = 2'h3;
    localparam logic [2:0] BALANCE_CODE_OFF = 3'h7;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [VPCR_ADDR_W-1:0] addr;
        logic write;
        logic read;
        logic [VPCR_DATA_W-1:0] writeData;
    } vpcr_req_s;

    typedef struct packed {
        logic valid;
        logic [VPCR_DATA_W-1:0] readData;
    } vpcr_rsp_s;

    typedef struct packed {
        logic analogLoopFull;
        logic digitalLoopEnable;
        logic analogLoopFirst;
        logic receiveHpfBypass;
        logic transmitHpfBypass;
        logic transmitMute;
        logic receiveMute;
        logic [1:0] transmitAnalogGain;
        logic transmitAnalogMute;
        logic [1:0] receiveAnalogGain;
        logic receiveAnalogMute;
        logic [1:0] lineCapCompensation;
        logic impedanceSynthEnable;
        logic [2:0] impedanceSynthSelect;
        logic [2:0] meteringBalanceCode;
        logic meteringBalanceOff;
        logic [2:0] audioBalanceCode;
        logic audioBalanceOff;
    } vpcr_ctrl_s;

    typedef struct packed {
        logic [1:0] drive;
        logic [1:0] enable;
        logic outPin;
    } vpcr_pins_s;

endpackage

// >>> logic/vpcr_regs.sv
`timescale 1ns/10ps
module vpcr_regs #(
    parameter bit HAS_GP_PINS = 1'b1,
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire vpcr_pkg::vpcr_req_s regReq,
    output vpcr_pkg::vpcr_rsp_s regRsp,
    output vpcr_pkg::vpcr_ctrl_s voiceCtrl,
    input wire logic [1:0] gpPinIn,
    output logic [1:0] gpPinOut,
    output logic [1:0] gpPinOe,
    output logic gpOutPin,
    output logic lineCapReservedCode
);
    import vpcr_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (ADDR_W != VPCR_ADDR_W) begin : g_bad_addr
        $error("vpcr_regs: ADDR_W must equal the package address width");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] generalPinControl;
        logic [7:0] loopbackControl;
        logic [7:0] audioGainControl;
        logic [7:0] impedanceSynthesisControl;
        logic [7:0] hybridBalanceControl;
        logic [1:0] pinSync1;
        logic [1:0] pinSync2;
        logic [1:0] pinSync3;
        logic [1:0] pinLevel;
        vpcr_rsp_s rsp;
        vpcr_ctrl_s ctrl;
        vpcr_pins_s pins;
        logic lineCapReserved;
    } vpcr_state_s;

    localparam vpcr_state_s STATE_RESET = '{
        generalPinControl: GENERAL_PIN_CONTROL_RST,
        loopbackControl: LOOPBACK_CONTROL_RST,
        audioGainControl: AUDIO_GAIN_CONTROL_RST,
        impedanceSynthesisControl: IMPEDANCE_SYNTHESIS_CONTROL_RST,
        hybridBalanceControl: HYBRID_BALANCE_CONTROL_RST,
        pinSync1: 2'h0,
        pinSync2: 2'h0,
        pinSync3: 2'h0,
        pinLevel: 2'h0,
        rsp: '0,
        ctrl: '{
            analogLoopFull: 1'b0,
            digitalLoopEnable: 1'b1,
            analogLoopFirst: 1'b0,
            receiveHpfBypass: 1'b0,
            transmitHpfBypass: 1'b0,
            transmitMute: 1'b0,
            receiveMute: 1'b0,
            transmitAnalogGain: ANALOG_GAIN_0DB,
            transmitAnalogMute: 1'b0,
            receiveAnalogGain: ANALOG_GAIN_0DB,
            receiveAnalogMute: 1'b0,
            lineCapCompensation: 2'h0,
            impedanceSynthEnable: 1'b1,
            impedanceSynthSelect: 3'h0,
            meteringBalanceCode: 3'h3,
            meteringBalanceOff: 1'b0,
            audioBalanceCode: 3'h3,
            audioBalanceOff: 1'b0
        },
        pins: '0,
        lineCapReserved: 1'b0
    };

    vpcr_state_s state_reg;
    vpcr_state_s state_next;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [7:0] wdata;
        logic [7:0] pinReadBack;
        logic [1:0] gain;
        state_next = state_reg;
        wdata = regReq.writeData;
        pinReadBack = 8'h00;
        gain = 2'h0;

        // Pin inputs: three flops, change taken when second and third agree
        state_next.pinSync1 = gpPinIn;
        state_next.pinSync2 = state_reg.pinSync1;
        state_next.pinSync3 = state_reg.pinSync2;
        for (int i = 0; i < 2; i++) begin
            if (state_reg.pinSync2[i] == state_reg.pinSync3[i]) begin
                state_next.pinLevel[i] = state_reg.pinSync3[i];
            end
        end

        // Register writes, reserved bits masked off
        if (regReq.write) begin
            case (regReq.addr)
                GENERAL_PIN_CONTROL_OFS: begin
                    if (HAS_GP_PINS) begin
                        state_next.generalPinControl = wdata & GENERAL_PIN_CONTROL_MASK;
                    end
                end
                LOOPBACK_CONTROL_OFS: begin
                    state_next.loopbackControl = wdata & LOOPBACK_CONTROL_MASK;
                end
                AUDIO_GAIN_CONTROL_OFS: begin
                    state_next.audioGainControl = wdata & AUDIO_GAIN_CONTROL_MASK;
                end
                IMPEDANCE_SYNTHESIS_CONTROL_OFS: begin
                    state_next.impedanceSynthesisControl =
                        wdata & IMPEDANCE_SYNTHESIS_CONTROL_MASK;
                end
                HYBRID_BALANCE_CONTROL_OFS: begin
                    state_next.hybridBalanceControl = wdata & HYBRID_BALANCE_CONTROL_MASK;
                end
                default: begin
                end
            endcase
        end

        // Input pins read back their sampled level
        pinReadBack = state_reg.generalPinControl;
        if (!state_reg.generalPinControl[GP_PIN1_DIRECTION_BIT]) begin
            pinReadBack[GP_PIN1_VALUE_BIT] = state_reg.pinLevel[0];
        end
        if (!state_reg.generalPinControl[GP_PIN2_DIRECTION_BIT]) begin
            pinReadBack[GP_PIN2_VALUE_BIT] = state_reg.pinLevel[1];
        end

        // Register reads, answered one cycle later
        state_next.rsp.valid = regReq.read;
        state_next.rsp.readData = 8'h00;
        if (regReq.read) begin
            case (regReq.addr)
                GENERAL_PIN_CONTROL_OFS: begin
                    state_next.rsp.readData = HAS_GP_PINS ? pinReadBack : 8'h00;
                end
                LOOPBACK_CONTROL_OFS: begin
                    state_next.rsp.readData = state_reg.loopbackControl;
                end
                AUDIO_GAIN_CONTROL_OFS: begin
                    state_next.rsp.readData = state_reg.audioGainControl;
                end
                IMPEDANCE_SYNTHESIS_CONTROL_OFS: begin
                    state_next.rsp.readData = state_reg.impedanceSynthesisControl;
                end
                HYBRID_BALANCE_CONTROL_OFS: begin
                    state_next.rsp.readData = state_reg.hybridBalanceControl;
                end
                default: begin
                    state_next.rsp.readData = 8'h00;
                end
            endcase
        end

        // Pin drivers follow the new register contents
        state_next.pins.outPin =
            HAS_GP_PINS & state_next.generalPinControl[GP_OUT_PIN_VALUE_BIT];
        state_next.pins.enable[0] =
            HAS_GP_PINS & state_next.generalPinControl[GP_PIN1_DIRECTION_BIT];
        state_next.pins.enable[1] =
            HAS_GP_PINS & state_next.generalPinControl[GP_PIN2_DIRECTION_BIT];
        state_next.pins.drive[0] =
            state_next.generalPinControl[GP_PIN1_VALUE_BIT] & state_next.pins.enable[0];
        state_next.pins.drive[1] =
            state_next.generalPinControl[GP_PIN2_VALUE_BIT] & state_next.pins.enable[1];

        // Loopback modes
        state_next.ctrl.analogLoopFull =
            state_next.loopbackControl[ANALOG_LOOP_FULL_BIT];
        state_next.ctrl.digitalLoopEnable =
            state_next.loopbackControl[DIGITAL_LOOP_ENABLE_BIT];
        state_next.ctrl.analogLoopFirst =
            state_next.loopbackControl[ANALOG_LOOP_FIRST_BIT];

        // Filters, digital mutes
        state_next.ctrl.receiveHpfBypass =
            state_next.audioGainControl[RECEIVE_HPF_BYPASS_BIT];
        state_next.ctrl.transmitHpfBypass =
            state_next.audioGainControl[TRANSMIT_HPF_BYPASS_BIT];
        state_next.ctrl.transmitMute =
            state_next.audioGainControl[TRANSMIT_MUTE_BIT];
        state_next.ctrl.receiveMute =
            state_next.audioGainControl[RECEIVE_MUTE_BIT];

        // Analog gains; mute code keeps transmit gain at 0 dB
        gain = state_next.audioGainControl[TRANSMIT_ANALOG_GAIN_LSB +: 2];
        state_next.ctrl.transmitAnalogMute = (gain == ANALOG_GAIN_MUTE);
        state_next.ctrl.transmitAnalogGain =
            (gain == ANALOG_GAIN_MUTE) ? ANALOG_GAIN_0DB : gain;
        gain = state_next.audioGainControl[RECEIVE_ANALOG_GAIN_LSB +: 2];
        state_next.ctrl.receiveAnalogMute = (gain == ANALOG_GAIN_MUTE);
        state_next.ctrl.receiveAnalogGain = gain;

        // Impedance synthesis and line compensation
        state_next.ctrl.lineCapCompensation =
            state_next.impedanceSynthesisControl[LINE_CAP_COMPENSATION_LSB +: 2];
        state_next.lineCapReserved =
            (state_next.ctrl.lineCapCompensation == LINE_CAP_RESERVED);
        state_next.ctrl.impedanceSynthEnable =
            state_next.impedanceSynthesisControl[IMPEDANCE_SYNTH_ENABLE_BIT];
        state_next.ctrl.impedanceSynthSelect =
            state_next.impedanceSynthesisControl[IMPEDANCE_SYNTH_SELECT_LSB +: 3];

        // Hybrid balance
        state_next.ctrl.meteringBalanceCode =
            state_next.hybridBalanceControl[METERING_BALANCE_CODE_LSB +: 3];
        state_next.ctrl.meteringBalanceOff =
            (state_next.ctrl.meteringBalanceCode == BALANCE_CODE_OFF);
        state_next.ctrl.audioBalanceCode =
            state_next.hybridBalanceControl[AUDIO_BALANCE_CODE_LSB +: 3];
        state_next.ctrl.audioBalanceOff =
            (state_next.ctrl.audioBalanceCode == BALANCE_CODE_OFF);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign regRsp = state_reg.rsp;
    assign voiceCtrl = state_reg.ctrl;
    assign gpPinOut = state_reg.pins.drive;
    assign gpPinOe = state_reg.pins.enable;
    assign gpOutPin = state_reg.pins.outPin;
    assign lineCapReservedCode = state_reg.lineCapReserved;

endmodule

// >>> bench/vpcr_regs_chk.sv
`timescale 1ns/10ps
module vpcr_regs_chk (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire vpcr_pkg::vpcr_req_s regReq,
    input wire vpcr_pkg::vpcr_rsp_s regRsp,
    input wire vpcr_pkg::vpcr_ctrl_s voiceCtrl,
    input wire logic [1:0] gpPinIn,
    input wire logic [1:0] gpPinOut,
    input wire logic [1:0] gpPinOe,
    input wire logic gpOutPin,
    input wire logic lineCapReservedCode
);
    import vpcr_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] wd;
    logic wrPin, wrLoop, wrGain, wrImp, mapped;
    assign wd = regReq.writeData;
    assign wrPin = regReq.write && regReq.addr == 8'h06;
    assign wrLoop = regReq.write && regReq.addr == 8'h08;
    assign wrGain = regReq.write && regReq.addr == 8'h09;
    assign wrImp = regReq.write && regReq.addr == 8'h0a;
    assign mapped = regReq.addr inside {8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b};
    // ****************************************************************
    // Properties
    // ****************************************************************
    chk_pin_drive: assert property (wrPin |=> gpPinOe == $past(wd[3:2]) &&
        gpPinOut == $past(wd[3:2] & wd[1:0]) && gpOutPin == $past(wd[4]))
        else $error("pin drive mismatch");
    chk_loop_bits: assert property (wrLoop |=> {voiceCtrl.analogLoopFull,
        voiceCtrl.digitalLoopEnable, voiceCtrl.analogLoopFirst} == $past(wd[2:0]))
        else $error("loopback control mismatch");
    chk_gain_bits: assert property (wrGain |=> {voiceCtrl.receiveHpfBypass,
        voiceCtrl.transmitHpfBypass, voiceCtrl.transmitMute, voiceCtrl.receiveMute,
        voiceCtrl.receiveAnalogGain} == $past({wd[7:4], wd[1:0]}))
        else $error("gain control mismatch");
    chk_tx_gain: assert property (wrGain |=> voiceCtrl.transmitAnalogMute ==
        ($past(wd[3:2]) == 2'h3) && voiceCtrl.transmitAnalogGain ==
        ($past(wd[3:2]) == 2'h3 ? 2'h0 : $past(wd[3:2])))
        else $error("transmit gain mismatch");
    chk_rx_mute: assert property (voiceCtrl.receiveAnalogMute ==
        (voiceCtrl.receiveAnalogGain == ANALOG_GAIN_MUTE)) else $error("receive mute wrong");
    chk_cap_code: assert property (lineCapReservedCode ==
        (voiceCtrl.lineCapCompensation == LINE_CAP_RESERVED)) else $error("cap flag wrong");
    chk_synth_ctrl: assert property (wrImp |=> {voiceCtrl.lineCapCompensation,
        voiceCtrl.impedanceSynthEnable, voiceCtrl.impedanceSynthSelect} == $past(wd[5:0]))
        else $error("synthesis control mismatch");
    chk_balance_off: assert property (
        voiceCtrl.meteringBalanceOff == (voiceCtrl.meteringBalanceCode == BALANCE_CODE_OFF) &&
        voiceCtrl.audioBalanceOff == (voiceCtrl.audioBalanceCode == BALANCE_CODE_OFF))
        else $error("balance off flag wrong");
    chk_read_pulse: assert property (regRsp.valid == $past(regReq.read))
        else $error("read valid timing wrong");
    chk_unmapped_zero: assert property (regReq.read && !mapped |=>
        regRsp.valid && regRsp.readData == 8'h00) else $error("unmapped read not zero");
    cover property (wrPin && wd[3:2] == 2'b11);
    cover property (regReq.read && !mapped);
    cover property (wrGain && wd[3:2] == 2'h3);
endmodule

// >>> bench/vpcr_regs_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin errTotal++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module vpcr_regs_tb;
    import vpcr_pkg::*;
    logic core_clk, reset_n, gpOutPin, lineCapReservedCode;
    vpcr_req_s regReq;
    vpcr_rsp_s regRsp;
    vpcr_ctrl_s voiceCtrl;
    logic [1:0] extPin, gpPinOut, gpPinOe;
    wire logic [1:0] gpPinIn = (gpPinOe & gpPinOut) | (~gpPinOe & extPin);
    int errTotal = 0;
    int checksDone = 0;
    int cycles = 0;
    vpcr_regs DUT (.core_clk(core_clk), .reset_n(reset_n), .regReq(regReq),
        .regRsp(regRsp), .voiceCtrl(voiceCtrl), .gpPinIn(gpPinIn), .gpPinOut(gpPinOut),
        .gpPinOe(gpPinOe), .gpOutPin(gpOutPin), .lineCapReservedCode(lineCapReservedCode));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regReq <= '{addr: a, write: 1'b1, read: 1'b0, writeData: d};
        @(posedge core_clk);
        regReq.write <= 1'b0;
        #1;
    endtask
    task automatic chkRd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge core_clk);
        regReq <= '{addr: a, write: 1'b0, read: 1'b1, writeData: 8'h00};
        @(posedge core_clk);
        regReq.read <= 1'b0;
        #1;
        `CHK("read valid", 1'b1, regRsp.valid)
        `CHK(nm, e, regRsp.readData)
    endtask
    task automatic completeRun();
        $display("Checks done %0d, errors %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic testReset();
        chkRd(8'h08, 8'h02, "loop reset");
        chkRd(8'h09, 8'h00, "gain reset");
        chkRd(8'h0a, 8'h08, "imp reset");
        chkRd(8'h0b, 8'h33, "hybrid reset");
        chkRd(8'h06, 8'h00, "pin reset");
        `CHK("digital loop", 1'b1, voiceCtrl.digitalLoopEnable)
        `CHK("synth enable", 1'b1, voiceCtrl.impedanceSynthEnable)
        `CHK("pin oe reset", 2'b00, gpPinOe)
        `CHK("out pin reset", 1'b0, gpOutPin)
    endtask
    task automatic testReserved();
        logic [7:0] addrs [8] = '{8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h07, 8'h0c, 8'hff};
        logic [7:0] masks [8] = '{8'h1f, 8'h07, 8'hff, 8'h3f, 8'h77, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            wrReg(addrs[i], 8'hff);
            chkRd(addrs[i], masks[i], "write ones");
        end
    endtask
    task automatic testPins();
        wrReg(8'h06, 8'h1d);
        `CHK("oe both", 2'b11, gpPinOe)
        `CHK("drive both", 2'b01, gpPinOut)
        `CHK("out pin high", 1'b1, gpOutPin)
        wrReg(8'h06, 8'h0a);
        `CHK("oe pin2", 2'b10, gpPinOe)
        `CHK("drive pin2", 2'b10, gpPinOut)
        `CHK("out pin low", 1'b0, gpOutPin)
        @(posedge core_clk);
        extPin <= 2'b11;
        repeat (5) @(posedge core_clk);
        chkRd(8'h06, 8'h0b, "mixed read");
        wrReg(8'h06, 8'h00);
        @(posedge core_clk);
        extPin <= 2'b10;
        repeat (5) @(posedge core_clk);
        chkRd(8'h06, 8'h02, "input read");
        `CHK("oe none", 2'b00, gpPinOe)
    endtask
    task automatic testAudio();
        logic [1:0] k;
        for (int c = 0; c < 4; c++) begin
            k = c[1:0];
            wrReg(8'h09, {k, k, k, k});
            `CHK("hpf mute", {k, k}, {voiceCtrl.receiveHpfBypass, voiceCtrl.transmitHpfBypass,
                voiceCtrl.transmitMute, voiceCtrl.receiveMute})
            `CHK("tx gain", (k == 2'h3) ? 2'h0 : k, voiceCtrl.transmitAnalogGain)
            `CHK("tx mute", k == 2'h3, voiceCtrl.transmitAnalogMute)
            `CHK("rx gain", k, voiceCtrl.receiveAnalogGain)
            `CHK("rx mute", k == 2'h3, voiceCtrl.receiveAnalogMute)
        end
    endtask
    task automatic testImp();
        logic [2:0] k;
        for (int c = 0; c < 8; c++) begin
            k = c[2:0];
            wrReg(8'h0a, {2'b00, k[1:0], k[0], k});
            `CHK("cap code", k[1:0], voiceCtrl.lineCapCompensation)
            `CHK("cap reserved", k[1:0] == 2'h3, lineCapReservedCode)
            `CHK("synth enable", k[0], voiceCtrl.impedanceSynthEnable)
            `CHK("synth select", k, voiceCtrl.impedanceSynthSelect)
            wrReg(8'h08, {5'h00, k});
            `CHK("loop modes", k, {voiceCtrl.analogLoopFull, voiceCtrl.digitalLoopEnable,
                voiceCtrl.analogLoopFirst})
            wrReg(8'h0b, {1'b0, k, 1'b0, ~k});
            `CHK("meter code", k, voiceCtrl.meteringBalanceCode)
            `CHK("meter off", k == 3'h7, voiceCtrl.meteringBalanceOff)
            `CHK("audio code", ~k, voiceCtrl.audioBalanceCode)
            `CHK("audio off", k == 3'h0, voiceCtrl.audioBalanceOff)
        end
    endtask
    initial begin
        reset_n = 1'b0;
        regReq = '0;
        extPin = 2'b00;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        testReset();
        testReserved();
        testPins();
        testAudio();
        testImp();
        completeRun();
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errTotal++;
            $display("ERROR cycle limit expected done seen running");
            completeRun();
        end
    end
endmodule
bind vpcr_regs vpcr_regs_chk chkInst (.core_clk(core_clk), .reset_n(reset_n),
    .regReq(regReq), .regRsp(regRsp), .voiceCtrl(voiceCtrl), .gpPinIn(gpPinIn),
    .gpPinOut(gpPinOut), .gpPinOe(gpPinOe), .gpOutPin(gpOutPin),
    .lineCapReservedCode(lineCapReservedCode));
